/* hw/ocm_pkg.sv */
// Constants and types for the optical cable module management block
package ocm_pkg;

  // ****************************************
  // Serial bus and memory layout
  // ****************************************
  // Eight-bit form of the bus address is A0
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam int BYTE_BITS = 8;
  localparam int PAGE_BYTES = 128;
  localparam int NUM_PAGES = 2;
  localparam logic [7:0] OFS_STATUS = 8'h02;
  localparam logic [7:0] OFS_FLAGS = 8'h03;
  localparam logic [7:0] OFS_MON_HI = 8'h16;
  localparam logic [7:0] OFS_MON_LO = 8'h17;
  localparam logic [7:0] OFS_PAGE_SEL = 8'h7F;
  localparam int STATUS_DNR_BIT = 0;
  localparam logic [7:0] MEM_RESET_VAL = 8'h00;
  localparam int FLAG_BITS = 8;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_RESET_INIT_NS = 10_000;
  localparam int T_RESET_INIT_CYC =
    (T_RESET_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_INIT_NS = 2_000_000;
  localparam int T_INIT_CYC = T_INIT_NS / CLK_PERIOD_NS;

  // ****************************************
  // State types
  // ****************************************
  typedef enum logic [1:0] {
    RS_HELD = 2'b00,
    RS_INIT = 2'b01,
    RS_READY = 2'b11
  } ocm_rst_e;

  typedef enum logic [2:0] {
    TW_IDLE = 3'b000,
    TW_ADDR = 3'b001,
    TW_AACK = 3'b011,
    TW_OFFS = 3'b010,
    TW_DACK = 3'b110,
    TW_WRITE = 3'b111,
    TW_READ = 3'b101,
    TW_RACK = 3'b100
  } ocm_twi_e;

endpackage

/* hw/ocm_mem_if.sv */
// Memory access carrier between the serial slave and the management core
`timescale 1ns/1ns
interface ocm_mem_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic we;
  logic rd;
  logic [7:0] rdata;
  logic enable;
  modport slave (output addr, wdata, we, rd, input rdata, enable);
  modport mem (input addr, wdata, we, rd, output rdata, enable);
endinterface

/* hw/ocm_twi_slave.sv */
// Two-wire serial slave with byte offset pointer
`timescale 1ns/1ns
module ocm_twi_slave
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  // Memory side
  ocm_mem_if.slave m
);

  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  ocm_pkg::ocm_twi_e state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg, addr_reg, wdata_reg;
  logic rw_reg, wrote_reg, oe_reg, we_reg, rd_reg;
  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  wire start = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire stop = scl_s2 & scl_d & ~sda_d & sda_s2;
  wire byte_done = scl_fall && (cnt_reg == 4'(ocm_pkg::BYTE_BITS));
  wire addr_hit = shift_reg[7:1] == ocm_pkg::DEV_ADDR;

  assign sda_oe = oe_reg;
  assign m.addr = addr_reg;
  assign m.wdata = wdata_reg;
  assign m.we = we_reg;
  assign m.rd = rd_reg;

  // ****************************************
  // Pin synchronisers, idle level high
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {scl_s1, scl_s2, scl_d} <= 3'h7;
      {sda_s1, sda_s2, sda_d} <= 3'h7;
    end
    else if (ce)
    begin
      {scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
    end
  end

  // ****************************************
  // Protocol engine
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ocm_pkg::TW_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      {rw_reg, wrote_reg, oe_reg, we_reg, rd_reg} <= 5'h00;
    end
    else if (ce)
    begin
      we_reg <= 1'b0;
      rd_reg <= 1'b0;
      if (!m.enable || stop)
      begin
        state_reg <= ocm_pkg::TW_IDLE;
        oe_reg <= 1'b0;
      end
      else if (start)
      begin
        state_reg <= ocm_pkg::TW_ADDR;
        cnt_reg <= 4'h0;
        oe_reg <= 1'b0;
      end
      else
        case (state_reg)
          ocm_pkg::TW_ADDR, ocm_pkg::TW_OFFS, ocm_pkg::TW_WRITE:
            if (scl_rise)
            begin
              shift_reg <= {shift_reg[6:0], sda_s2};
              cnt_reg <= cnt_reg + 4'h1;
            end
            else if (byte_done)
            begin
              cnt_reg <= 4'h0;
              oe_reg <= 1'b1;
              if (state_reg == ocm_pkg::TW_ADDR)
              begin
                rw_reg <= shift_reg[0];
                oe_reg <= addr_hit;
                state_reg <= addr_hit ? ocm_pkg::TW_AACK : ocm_pkg::TW_IDLE;
              end
              else if (state_reg == ocm_pkg::TW_OFFS)
              begin
                addr_reg <= shift_reg;
                wrote_reg <= 1'b0;
                state_reg <= ocm_pkg::TW_DACK;
              end
              else
              begin
                wdata_reg <= shift_reg;
                we_reg <= 1'b1;
                wrote_reg <= 1'b1;
                state_reg <= ocm_pkg::TW_DACK;
              end
            end
          ocm_pkg::TW_AACK, ocm_pkg::TW_RACK:
            if (scl_rise && state_reg == ocm_pkg::TW_RACK && sda_s2)
              state_reg <= ocm_pkg::TW_IDLE;
            else if (scl_fall && (rw_reg || state_reg == ocm_pkg::TW_RACK))
            begin
              shift_reg <= m.rdata;
              oe_reg <= ~m.rdata[7];
              rd_reg <= 1'b1;
              cnt_reg <= 4'h0;
              state_reg <= ocm_pkg::TW_READ;
            end
            else if (scl_fall)
            begin
              oe_reg <= 1'b0;
              state_reg <= ocm_pkg::TW_OFFS;
            end
          ocm_pkg::TW_DACK:
            if (scl_fall)
            begin
              oe_reg <= 1'b0;
              state_reg <= ocm_pkg::TW_WRITE;
              if (wrote_reg)
                addr_reg <= addr_reg + 8'h01;
            end
          ocm_pkg::TW_READ:
            if (scl_rise)
              cnt_reg <= cnt_reg + 4'h1;
            else if (byte_done)
            begin
              oe_reg <= 1'b0;
              addr_reg <= addr_reg + 8'h01;
              state_reg <= ocm_pkg::TW_RACK;
            end
            else if (scl_fall)
            begin
              oe_reg <= ~shift_reg[6];
              shift_reg <= {shift_reg[6:0], 1'b0};
            end
          default:
            oe_reg <= 1'b0;
        endcase
    end
  end

endmodule

/* hw/ocm_top.sv */
// Management core of a four-lane active optical cable module
//
// Summary of operation
// - Select low: answer serial bus commands
// - Select high: ignore all bus traffic
// - Undriven select counts as deselected
// - Long reset low restores all settings
// - Reset interval starts at reset release
// - Completion: interrupt with not-ready bit clear
// - Power-up also posts completion interrupt
// - Low-power input high enters reduced power
// - Presence output low while inserted
// - Interrupt pin pulled low on faults
// - One 128-byte lower page, paged upper window
// - Lower page holds flags and monitors
// - Upper pages chosen by page select
// - Answer at bus address A0 hex
`timescale 1ns/1ns
module ocm_top
#(
  parameter int NUM_PAGES = ocm_pkg::NUM_PAGES,
  parameter int T_RESET_INIT_CYC = ocm_pkg::T_RESET_INIT_CYC,
  parameter int T_INIT_CYC = ocm_pkg::T_INIT_CYC
)
(
  // Clock, reset, enable
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  // Host control pins
  input wire logic MODULE_SELECT_N,
  input wire logic MODULE_RESET_N,
  input wire logic LOW_POWER_SELECT,
  // Serial bus pins
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // Status pins
  output logic MODULE_PRESENT_N,
  output logic INTERRUPT_OUT_N,
  output logic INTERRUPT_OE,
  output logic LOW_POWER_STATE,
  // Module internals
  input wire logic [ocm_pkg::FLAG_BITS-1:0] FLAG_IN,
  input wire logic [15:0] MONITOR_IN
);

  localparam int ENTRIES = ocm_pkg::PAGE_BYTES * (NUM_PAGES + 1);
  localparam int IDX_W = $clog2(ENTRIES);
  localparam int CNT_W = $clog2(T_INIT_CYC + T_RESET_INIT_CYC + 1);

  ocm_mem_if mif ();

  logic sel_s1, sel_s2, rst_s1, rst_s2, lp_s1, lp_s2;
  ocm_pkg::ocm_rst_e state_reg;
  logic [CNT_W-1:0] low_cnt_reg, init_cnt_reg;
  logic done_reg, int_n_reg, int_oe_reg, lp_reg;
  logic [ocm_pkg::FLAG_BITS-1:0] flags_reg;
  logic [7:0] mem_reg [ENTRIES];
  logic sda_oe_w;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      {sel_s1, sel_s2} <= 2'h3;
      {rst_s1, rst_s2} <= 2'h3;
      {lp_s1, lp_s2} <= 2'h0;
    end
    else if (CLK_EN)
    begin
      {sel_s1, sel_s2} <= {MODULE_SELECT_N, sel_s1};
      {rst_s1, rst_s2} <= {MODULE_RESET_N, rst_s1};
      {lp_s1, lp_s2} <= {LOW_POWER_SELECT, lp_s1};
    end
  end

  // ****************************************
  // Reset sequencing
  // ****************************************
  wire long_low = low_cnt_reg == CNT_W'(T_RESET_INIT_CYC);
  wire full_reset = !rst_s2 && long_low;
  wire init_end = init_cnt_reg == CNT_W'(T_INIT_CYC - 1);
  wire ready = state_reg == ocm_pkg::RS_READY;

  // Power-up starts in the interval itself, so no host pulse is needed
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_reg <= ocm_pkg::RS_INIT;
      low_cnt_reg <= '0;
      init_cnt_reg <= '0;
    end
    else if (CLK_EN)
    begin
      low_cnt_reg <= rst_s2 ? '0 : long_low ? low_cnt_reg : low_cnt_reg + 1'b1;
      case (state_reg)
        ocm_pkg::RS_HELD:
          if (rst_s2)
          begin
            state_reg <= ocm_pkg::RS_INIT;
            init_cnt_reg <= '0;
          end
        ocm_pkg::RS_INIT:
          if (full_reset)
            state_reg <= ocm_pkg::RS_HELD;
          else if (init_end)
            state_reg <= ocm_pkg::RS_READY;
          else
            init_cnt_reg <= init_cnt_reg + 1'b1;
        ocm_pkg::RS_READY:
          if (full_reset)
            state_reg <= ocm_pkg::RS_HELD;
        default:
          state_reg <= ocm_pkg::RS_HELD;
      endcase
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  wire [7:0] page = mem_reg[ocm_pkg::OFS_PAGE_SEL];
  wire upper = mif.addr[7];
  wire page_ok = page < 8'(NUM_PAGES);
  wire [IDX_W-1:0] up_idx = IDX_W'(ocm_pkg::PAGE_BYTES)
    * (IDX_W'(page) + 1'b1) + IDX_W'(mif.addr[6:0]);
  wire [IDX_W-1:0] widx = upper ? up_idx : IDX_W'(mif.addr);
  wire is_status = mif.addr == ocm_pkg::OFS_STATUS;
  wire is_flags = mif.addr == ocm_pkg::OFS_FLAGS;
  wire is_mon_hi = mif.addr == ocm_pkg::OFS_MON_HI;
  wire is_mon_lo = mif.addr == ocm_pkg::OFS_MON_LO;
  wire read_only = is_status | is_flags | is_mon_hi | is_mon_lo;
  wire mem_we = mif.we && !read_only && (!upper || page_ok);
  wire [7:0] status_byte = 8'(!ready) << ocm_pkg::STATUS_DNR_BIT;
  wire flags_rd = mif.rd && is_flags;
  wire status_rd = mif.rd && is_status;

  // Flags and monitors sit in the lower page for one-pass reads
  assign mif.rdata = is_status ? status_byte
    : is_flags ? flags_reg
    : is_mon_hi ? MONITOR_IN[15:8]
    : is_mon_lo ? MONITOR_IN[7:0]
    : (upper && !page_ok) ? 8'h00
    : mem_reg[widx];
  // Bus stays dead until the interval is over
  assign mif.enable = !sel_s2 && ready;

  // ****************************************
  // Management memory
  // ****************************************
  for (genvar i = 0; i < ENTRIES; i++)
  begin : g_mem
    always_ff @(posedge CORE_CLK or negedge RST_B)
    begin
      if (!RST_B)
        mem_reg[i] <= ocm_pkg::MEM_RESET_VAL;
      else if (CLK_EN && full_reset)
        mem_reg[i] <= ocm_pkg::MEM_RESET_VAL;
      else if (CLK_EN && mem_we && widx == IDX_W'(i))
        mem_reg[i] <= mif.wdata;
    end
  end

  // Sticky flags; a new event wins over the clearing read
  for (genvar b = 0; b < ocm_pkg::FLAG_BITS; b++)
  begin : g_flag
    always_ff @(posedge CORE_CLK or negedge RST_B)
    begin
      if (!RST_B)
        flags_reg[b] <= 1'b0;
      else if (CLK_EN)
        flags_reg[b] <= FLAG_IN[b] | (flags_reg[b] & !flags_rd);
    end
  end

  // ****************************************
  // Interrupt, presence and power
  // ****************************************
  wire done_set = state_reg == ocm_pkg::RS_INIT && init_end && !full_reset;
  wire int_act = ready && (done_reg || (|flags_reg));

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      done_reg <= 1'b0;
      int_n_reg <= 1'b1;
      int_oe_reg <= 1'b0;
      lp_reg <= 1'b0;
      MODULE_PRESENT_N <= 1'b0;
      SDA_OUT <= 1'b0;
    end
    else if (CLK_EN)
    begin
      done_reg <= done_set | (done_reg & !status_rd & ready);
      int_n_reg <= !int_act;
      int_oe_reg <= int_act;
      lp_reg <= lp_s2;
      MODULE_PRESENT_N <= 1'b0;
      SDA_OUT <= 1'b0;
    end
  end

  assign INTERRUPT_OUT_N = int_n_reg;
  assign INTERRUPT_OE = int_oe_reg;
  assign LOW_POWER_STATE = lp_reg;
  assign SDA_OE = sda_oe_w;

  ocm_twi_slave u_twi (
    .clk (CORE_CLK),
    .rst_n (RST_B),
    .ce (CLK_EN),
    .scl_in (SCL_IN),
    .sda_in (SDA_IN),
    .sda_oe (sda_oe_w),
    .m (mif.slave)
  );

endmodule

/* testbench/ocm_top_props.sv */
// Pin-level property checks for the management core
`timescale 1ns/1ns
module ocm_top_props
#(
  parameter int T_RESET_INIT_CYC = 8,
  parameter int T_INIT_CYC = 400
)
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  // Host pins
  input wire logic MODULE_SELECT_N,
  input wire logic MODULE_RESET_N,
  input wire logic LOW_POWER_SELECT,
  input wire logic [ocm_pkg::FLAG_BITS-1:0] FLAG_IN,
  // Module outputs
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic MODULE_PRESENT_N,
  input wire logic INTERRUPT_OUT_N,
  input wire logic INTERRUPT_OE,
  input wire logic LOW_POWER_STATE
);
  // ********
  // Counters
  // ********
  // Margins cover the pin synchronisers of the core
  int up_cnt;
  int lo_cnt;
  logic long_lo;
  assign long_lo = lo_cnt > T_RESET_INIT_CYC + 3;
  always_ff @(posedge CORE_CLK or negedge RST_B)
    if (!RST_B)
    begin
      up_cnt <= 0;
      lo_cnt <= 0;
    end
    else if (CLK_EN)
    begin
      up_cnt <= long_lo ? 0 : up_cnt + int'(up_cnt < T_INIT_CYC + 12);
      lo_cnt <= MODULE_RESET_N ? 0 : lo_cnt + int'(!long_lo);
    end
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);
  sequence s_desel;
    MODULE_SELECT_N [*6];
  endsequence
  sequence s_lp_on;
    (LOW_POWER_SELECT && CLK_EN) [*4];
  endsequence
  chk_desel_quiet:
    assert property (s_desel |-> !SDA_OE)
    else $error("data line pulled while deselected");
  chk_lp_enter:
    assert property (s_lp_on |-> LOW_POWER_STATE)
    else $error("low power state not entered");
  chk_lp_leave:
    assert property ((!LOW_POWER_SELECT && CLK_EN) [*4] |-> !LOW_POWER_STATE)
    else $error("low power state not left");
  chk_data_low:
    assert property (!SDA_OUT)
    else $error("data output level not low");
  chk_present_low:
    assert property (!MODULE_PRESENT_N)
    else $error("presence output high");
  chk_int_drive:
    assert property (INTERRUPT_OE == !INTERRUPT_OUT_N)
    else $error("interrupt enable and level disagree");
  chk_init_quiet:
    assert property (up_cnt < T_INIT_CYC |-> INTERRUPT_OUT_N && !SDA_OE)
    else $error("activity inside init interval");
  chk_done_post:
    assert property (up_cnt == T_INIT_CYC + 10 |-> !INTERRUPT_OUT_N)
    else $error("completion interrupt missing");
  chk_flag_raise:
    assert property (|FLAG_IN && up_cnt == T_INIT_CYC + 12
      |-> ##[1:4] !INTERRUPT_OUT_N)
    else $error("flag event raised no interrupt");
endmodule
bind ocm_top ocm_top_props #(
  .T_RESET_INIT_CYC(T_RESET_INIT_CYC),
  .T_INIT_CYC(T_INIT_CYC)
) i_props (
  .CORE_CLK(CORE_CLK), .RST_B(RST_B), .CLK_EN(CLK_EN),
  .MODULE_SELECT_N(MODULE_SELECT_N), .MODULE_RESET_N(MODULE_RESET_N),
  .LOW_POWER_SELECT(LOW_POWER_SELECT), .FLAG_IN(FLAG_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .MODULE_PRESENT_N(MODULE_PRESENT_N),
  .INTERRUPT_OUT_N(INTERRUPT_OUT_N), .INTERRUPT_OE(INTERRUPT_OE),
  .LOW_POWER_STATE(LOW_POWER_STATE)
);

/* testbench/ocm_host_model.sv */
// Host controller model driving the two-wire bus
`timescale 1ns/1ns
module ocm_host_model
(
  // Clock and bus
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic pull
);
  // ********
  // Bus cycles
  // ********
  // Clock rests high between frames
  initial
  begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic ph(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic start_c;
    pull = 1'b0;
    ph(4);
    scl = 1'b1;
    ph(4);
    pull = 1'b1;
    ph(4);
    scl = 1'b0;
    ph(4);
  endtask
  // Data held 2 cycles past the clock fall for hold time
  // Bit cell is 8 core cycles, a 160 ns serial clock
  task automatic bit_c(input logic b, output logic r);
    pull = !b;
    ph(2);
    scl = 1'b1;
    ph(4);
    r = sda;
    scl = 1'b0;
    ph(2);
  endtask
  task automatic xbyte(input logic [7:0] d, input logic ak_in,
                       output logic [7:0] q, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_c(d[i], q[i]);
    bit_c(ak_in, r);
    ak = !r;
  endtask
  task automatic stop_c;
    pull = 1'b1;
    ph(4);
    scl = 1'b1;
    ph(4);
    pull = 1'b0;
    ph(4);
  endtask
endmodule

/* testbench/tb.sv */
// Self-checking bench for the management core
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sel_en = 1'b1;
  logic sel_n = 1'b0;
  logic mrst_n = 1'b1;
  logic lp = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] flags = 8'h00;
  logic [15:0] mon = 16'hc35a;
  logic scl;
  logic pull;
  logic sda_oe;
  logic int_oe;
  logic present_n;
  logic lp_st;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  // Board pull-ups on select, data and interrupt lines
  tri1 sel_w;
  assign sel_w = sel_en ? sel_n : 1'bz;
  wire sda = !(sda_oe | pull);
  wire int_pin = !int_oe;
  ocm_top #(.T_RESET_INIT_CYC(8), .T_INIT_CYC(400)) i_dut (
    .CORE_CLK(clk), .RST_B(rst_b), .CLK_EN(clk_en),
    .MODULE_SELECT_N(sel_w), .MODULE_RESET_N(mrst_n),
    .LOW_POWER_SELECT(lp), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(),
    .SDA_OE(sda_oe), .MODULE_PRESENT_N(present_n), .INTERRUPT_OUT_N(),
    .INTERRUPT_OE(int_oe), .LOW_POWER_STATE(lp_st), .FLAG_IN(flags),
    .MONITOR_IN(mon)
  );
  ocm_host_model i_host (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
  // ********
  // Tasks
  // ********
  initial
  begin
    forever #10 clk = !clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      stop_test();
    end
  end
  task automatic acc(input logic [7:0] dev, input logic rd,
    input logic [7:0] ofs, input logic [7:0] wd,
    output logic [7:0] q, output logic ak);
    logic a0;
    logic a1;
    logic a2;
    logic nk;
    i_host.start_c();
    i_host.xbyte(dev, 1'b1, q, a0);
    i_host.xbyte(ofs, 1'b1, q, a1);
    if (rd)
    begin
      i_host.start_c();
      i_host.xbyte(dev | 8'h01, 1'b1, q, a2);
      i_host.xbyte(8'hff, 1'b1, q, nk);
    end
    else
      i_host.xbyte(wd, 1'b1, q, a2);
    i_host.stop_c();
    ak = a0 & a1 & a2;
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] q);
    logic ak;
    acc(8'ha0, 1'b1, ofs, 8'h00, q, ak);
    check({7'h00, ak}, 8'h01);
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] q;
    logic ak;
    acc(8'ha0, 1'b0, ofs, d, q, ak);
    check({7'h00, ak}, 8'h01);
  endtask
  task automatic wait_int;
    for (int n = 0; n < 800 && int_pin; n++)
      @(posedge clk);
    repeat (12) @(posedge clk);
    #1;
    check({7'h00, int_pin}, 8'h00);
  endtask
  task automatic t_powerup;
    logic [7:0] q;
    wait_int();
    check({7'h00, present_n}, 8'h00);
    rd(8'h02, q);
    check({7'h00, q[0]}, 8'h00);
    check({7'h00, int_pin}, 8'h01);
    $display("power-up done");
  endtask
  task automatic t_pages;
    logic [7:0] q;
    wr(8'h7f, 8'h01);
    wr(8'h80, 8'ha5);
    rd(8'h80, q);
    check(q, 8'ha5);
    // Page beyond the implemented set: writes dropped, reads zero
    wr(8'h7f, 8'h02);
    wr(8'h80, 8'h5a);
    rd(8'h80, q);
    check(q, 8'h00);
    wr(8'h7f, 8'h00);
    rd(8'h80, q);
    check(q, 8'h00);
    wr(8'h16, 8'h00);
    rd(8'h16, q);
    check(q, 8'hc3);
    rd(8'h17, q);
    check(q, 8'h5a);
    $display("pages done");
  endtask
  task automatic t_flags;
    logic [7:0] q;
    @(posedge clk);
    #1;
    flags = 8'ha5;
    @(posedge clk);
    #1;
    flags = 8'h00;
    repeat (5) @(posedge clk);
    #1;
    check({7'h00, int_pin}, 8'h00);
    rd(8'h03, q);
    check(q, 8'ha5);
    rd(8'h03, q);
    check(q, 8'h00);
    check({7'h00, int_pin}, 8'h01);
    $display("flags done");
  endtask
  task automatic t_select;
    logic [7:0] q;
    logic ak;
    sel_n = 1'b1;
    acc(8'ha0, 1'b1, 8'h02, 8'h00, q, ak);
    check({7'h00, ak}, 8'h00);
    sel_n = 1'b0;
    sel_en = 1'b0;
    acc(8'ha0, 1'b1, 8'h02, 8'h00, q, ak);
    check({7'h00, ak}, 8'h00);
    sel_en = 1'b1;
    acc(8'ha2, 1'b0, 8'h7f, 8'h01, q, ak);
    check({7'h00, ak}, 8'h00);
    $display("select done");
  endtask
  task automatic t_lowpower;
    // Frozen core must not follow the pin
    clk_en = 1'b0;
    lp = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    check({7'h00, lp_st}, 8'h00);
    clk_en = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    check({7'h00, lp_st}, 8'h01);
    lp = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check({7'h00, lp_st}, 8'h00);
    $display("low power done");
  endtask
  task automatic t_mreset;
    logic [7:0] q;
    logic ak;
    wr(8'h7f, 8'h01);
    mrst_n = 1'b0;
    repeat (14) @(posedge clk);
    #1;
    mrst_n = 1'b1;
    acc(8'ha0, 1'b0, 8'h80, 8'h11, q, ak);
    check({7'h00, ak}, 8'h00);
    wait_int();
    rd(8'h7f, q);
    check(q, 8'h00);
    rd(8'h02, q);
    check({7'h00, q[0]}, 8'h00);
    $display("module reset done");
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_powerup();
    t_pages();
    t_flags();
    t_select();
    t_lowpower();
    t_mreset();
    stop_test();
  end
endmodule
